// >>> pkg/tcm_pkg.sv
// Purpose: Shared constants for the connection memory block and its host.
// Assumes: One 125 MHz clock on both ends.
// Notes: Register offsets apply when host address bit 14 is low.
package tcm_pkg;
   localparam int CM_W = 16;
   localparam int CM_DEPTH = 8192;
   localparam int HA_W = 15;
   localparam int MEM_SEL_BIT = 14;
   localparam logic [2:0] MS_LOCAL = 3'h0;
   localparam logic [2:0] MS_BACKPLANE = 3'h1;
   localparam logic [13:0] REG_CTRL = 14'h0000;
   localparam logic [13:0] REG_FILL = 14'h0001;
   localparam int CTRL_MS_LSB = 0;
   localparam int CTRL_MODE_BIT = 3;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam int FILL_EN_BIT = 0;
   localparam int FILL_LOCAL_LSB = 1;
   localparam int FILL_BACK_LSB = 4;
   localparam logic [15:0] FILL_RESET = 16'h0000;
   localparam int W_SRC = 15;
   localparam int W_MSG = 14;
   localparam int W_DRIVE = 13;
   localparam int FILL_TIME_US = 125;
   localparam int CLK_MHZ = 125;
   localparam int FILL_MAX_CYC = FILL_TIME_US * CLK_MHZ;
endpackage : tcm_pkg

// >>> pkg/tcm_bus_if.sv
// Purpose: Parallel host port between the host end and the device end.
// Assumes: Both ends run on sys_clk.
// Notes: The data bus is split into per-direction signals with enables.
`timescale 1ns/1ps
`default_nettype none
interface tcm_bus_if;
   logic cs_n;
   logic ds_n;
   logic rw;
   logic [14:0] addr;
   logic [15:0] wdata;
   logic wdata_oe;
   logic [15:0] rdata;
   logic rdata_oe;
   logic dta_n;
   modport dev (input cs_n, ds_n, rw, addr, wdata, wdata_oe, output rdata, rdata_oe, dta_n);
   modport host (output cs_n, ds_n, rw, addr, wdata, wdata_oe, input rdata, rdata_oe, dta_n);
endinterface : tcm_bus_if
`default_nettype wire

// >>> logic/tcm_device_end.sv
// Purpose: Local and backplane connection memories with host access and block fill.
// Assumes: Host port inputs are synchronous to sys_clk; rate inputs are static.
// Notes: Slot lookups return the word as stored at lookup time.
`timescale 1ns/1ps
`default_nettype none
module tcm_device_end
   import tcm_pkg::*;
#(
   parameter int DEPTH = CM_DEPTH,
   parameter int FILL_LIMIT = FILL_MAX_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Host port
   tcm_bus_if.dev bus,
   // Reset output state straps
   input wire logic local_reset_output_state,
   input wire logic backplane_reset_output_state,
   // Per-port source rate, index 0 local and 1 backplane
   input wire logic [1:0] rate_32,
   // Slot lookup
   input wire logic slot_req,
   input wire logic [13:0] slot_addr,
   output logic slot_valid,
   output logic [1:0] src_is_local,
   output logic [1:0][4:0] src_stream,
   output logic [1:0][8:0] src_chan,
   output logic [1:0] msg_mode,
   output logic [1:0][7:0] msg_byte,
   output logic [1:0] drive_en,
   output logic [1:0] force_high,
   // Status
   output logic fill_busy
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(FILL_LIMIT + 1);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
   localparam logic [CW-1:0] LIMIT_C = CW'(FILL_LIMIT);

   typedef struct packed {
      logic [DEPTH-1:0][15:0] local_conn_mem;
      logic [DEPTH-1:0][15:0] backplane_conn_mem;
      logic [2:0] memory_select_field;
      logic fill_mode_bit;
      logic fill_armed;
      logic fill_enable_bit;
      logic [2:0] local_fill_bits;
      logic [2:0] backplane_fill_bits;
      logic [AW-1:0] fill_idx;
      logic [CW-1:0] fill_cyc;
      logic acked;
      logic [15:0] rdata;
      logic slot_valid;
      logic [1:0][15:0] slot_word;
   } tcm_dev_s;

   tcm_dev_s st_q;
   tcm_dev_s st_d;

   logic sel;
   logic [AW-1:0] mem_idx;
   logic [AW-1:0] slot_idx;
   logic [15:0] ctrl_val;
   logic [15:0] fill_val;

   assign sel = !bus.cs_n && !bus.ds_n;
   assign mem_idx = bus.addr[AW-1:0];
   assign slot_idx = slot_addr[AW-1:0];
   assign ctrl_val = {12'h000, st_q.fill_mode_bit, st_q.memory_select_field};
   assign fill_val = {9'h000, st_q.backplane_fill_bits, st_q.local_fill_bits,
      st_q.fill_enable_bit};

   always_comb begin
      st_d = st_q;
      st_d.slot_valid = 1'b0;
      // Filling, one location of each memory per cycle.
      if (st_q.fill_enable_bit) begin
         st_d.local_conn_mem[st_q.fill_idx] = {st_q.local_fill_bits, 13'h0000};
         st_d.backplane_conn_mem[st_q.fill_idx] = {st_q.backplane_fill_bits, 13'h0000};
         st_d.fill_idx = st_q.fill_idx + 1'b1;
         st_d.fill_cyc = st_q.fill_cyc + 1'b1;
         // The cycle watchdog only matters if DEPTH is raised past the time budget.
         if (st_q.fill_idx == LAST_IDX || st_q.fill_cyc == LIMIT_C) begin
            st_d.fill_enable_bit = 1'b0;
         end
      end
      // Host access is handled once per strobe; the acknowledge holds until release.
      if (!sel) begin
         st_d.acked = 1'b0;
      end else if (!st_q.acked) begin
         st_d.acked = 1'b1;
         if (bus.addr[MEM_SEL_BIT]) begin
            // Memory space.
            if (st_q.memory_select_field == MS_LOCAL) begin
               st_d.rdata = st_q.local_conn_mem[mem_idx];
               if (!bus.rw) begin
                  st_d.local_conn_mem[mem_idx] = bus.wdata;
               end
            end else if (st_q.memory_select_field == MS_BACKPLANE) begin
               st_d.rdata = st_q.backplane_conn_mem[mem_idx];
               if (!bus.rw) begin
                  st_d.backplane_conn_mem[mem_idx] = bus.wdata;
               end
            end else begin
               st_d.rdata = 16'h0000;
            end
         end else if (bus.addr[13:0] == REG_CTRL) begin
            st_d.rdata = ctrl_val;
            if (!bus.rw) begin
               st_d.memory_select_field = bus.wdata[CTRL_MS_LSB +: 3];
               st_d.fill_mode_bit = bus.wdata[CTRL_MODE_BIT];
               if (bus.wdata[CTRL_MODE_BIT] && !st_q.fill_mode_bit) begin
                  st_d.fill_armed = 1'b1;
               end else if (!bus.wdata[CTRL_MODE_BIT]) begin
                  st_d.fill_armed = 1'b0;
                  st_d.fill_enable_bit = 1'b0;
               end
            end
         end else if (bus.addr[13:0] == REG_FILL) begin
            st_d.rdata = fill_val;
            if (!bus.rw) begin
               st_d.local_fill_bits = bus.wdata[FILL_LOCAL_LSB +: 3];
               st_d.backplane_fill_bits = bus.wdata[FILL_BACK_LSB +: 3];
               if (!bus.wdata[FILL_EN_BIT]) begin
                  st_d.fill_enable_bit = 1'b0;
               end else if (st_q.fill_armed && !st_q.fill_enable_bit) begin
                  // A set written in the completion cycle is ignored; a set after completion restarts the fill.
                  st_d.fill_enable_bit = 1'b1;
                  st_d.fill_idx = '0;
                  st_d.fill_cyc = '0;
               end
            end
         end else begin
            st_d.rdata = 16'h0000;
         end
      end
      // Lookup sees writes made before it, so a new word acts from its next use.
      if (slot_req) begin
         st_d.slot_valid = 1'b1;
         st_d.slot_word[0] = st_q.local_conn_mem[slot_idx];
         st_d.slot_word[1] = st_q.backplane_conn_mem[slot_idx];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus.dta_n = !st_q.acked;
   assign bus.rdata = st_q.rdata;
   assign bus.rdata_oe = st_q.acked && sel && bus.rw;
   assign slot_valid = st_q.slot_valid;
   assign fill_busy = st_q.fill_enable_bit;

   logic [1:0] ros;
   assign ros = {backplane_reset_output_state, local_reset_output_state};

   for (genvar p = 0; p < 2; p++) begin : g_port
      logic [15:0] w;
      assign w = st_q.slot_word[p];
      if (p == 0) begin : g_loc
         assign src_is_local[p] = w[W_SRC];
      end else begin : g_bp
         assign src_is_local[p] = !w[W_SRC];
      end
      assign src_stream[p] = rate_32[p] ? {1'b0, w[12:9]} : w[12:8];
      assign src_chan[p] = rate_32[p] ? w[8:0] : {1'b0, w[7:0]};
      assign msg_mode[p] = w[W_MSG];
      assign msg_byte[p] = w[7:0];
      // A low strap drives high in reset, a high strap floats the channel.
      assign drive_en[p] = resetn ? w[W_DRIVE] : !ros[p];
      assign force_high[p] = !resetn && !ros[p];
   end
endmodule : tcm_device_end
`default_nettype wire

// >>> logic/tcm_host_end.sv
// Purpose: Host end that runs one strobed access on the parallel port per command.
// Assumes: Device answers with a low acknowledge held until strobes release.
// Notes: Arming and enabling a block fill are two separate register writes.
`timescale 1ns/1ps
`default_nettype none
module tcm_host_end
   import tcm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Host port
   tcm_bus_if.host bus,
   // User command
   input wire logic cmd_req,
   input wire logic cmd_write,
   input wire logic [14:0] cmd_addr,
   input wire logic [15:0] cmd_wdata,
   output logic cmd_ready,
   // User response
   output logic rsp_valid,
   output logic [15:0] rsp_rdata
);
   typedef enum logic [1:0] {
      H_IDLE,
      H_STROBE,
      H_RELEASE
   } tcm_host_e;

   typedef struct packed {
      tcm_host_e state;
      logic strobe;
      logic rw;
      logic [14:0] addr;
      logic [15:0] wdata;
      logic rsp_valid;
      logic [15:0] rdata;
   } tcm_host_s;

   tcm_host_s st_q;
   tcm_host_s st_d;

   always_comb begin
      st_d = st_q;
      st_d.rsp_valid = 1'b0;
      case (st_q.state)
         H_IDLE: begin
            if (cmd_req) begin
               st_d.strobe = 1'b1;
               st_d.rw = !cmd_write;
               st_d.addr = cmd_addr;
               st_d.wdata = cmd_wdata;
               st_d.state = H_STROBE;
            end
         end
         H_STROBE: begin
            if (!bus.dta_n) begin
               st_d.rdata = bus.rdata;
               st_d.strobe = 1'b0;
               st_d.state = H_RELEASE;
            end
         end
         H_RELEASE: begin
            if (bus.dta_n) begin
               st_d.rsp_valid = 1'b1;
               st_d.state = H_IDLE;
            end
         end
         default: begin
            st_d.state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus.cs_n = !st_q.strobe;
   assign bus.ds_n = !st_q.strobe;
   assign bus.rw = st_q.rw;
   assign bus.addr = st_q.addr;
   assign bus.wdata = st_q.wdata;
   assign bus.wdata_oe = st_q.strobe && !st_q.rw;
   assign cmd_ready = st_q.state == H_IDLE;
   assign rsp_valid = st_q.rsp_valid;
   assign rsp_rdata = st_q.rdata;
endmodule : tcm_host_end
`default_nettype wire

// >>> verif/tcm_props.sv
// Purpose: Handshake checks on the host port between the two ends.
// Assumes: One clock, synchronous active-low reset.
// Notes: Sees only interface wires, so slot decode is left to the bench.
`timescale 1ns/1ps
`default_nettype none
module tcm_props (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Host port
   input wire logic cs_n,
   input wire logic ds_n,
   input wire logic rw,
   input wire logic [14:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wdata_oe,
   input wire logic [15:0] rdata,
   input wire logic rdata_oe,
   input wire logic dta_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_req;
      !cs_n && !ds_n && dta_n;
   endsequence
   a_ack_fast: assert property (s_req |=> !dta_n) else $error("late ack");
   a_ack_hold: assert property (!dta_n && !cs_n && !ds_n |=> !dta_n)
      else $error("ack dropped early");
   a_ack_drop: assert property (!dta_n && (cs_n || ds_n) |=> dta_n)
      else $error("ack stuck");
   a_rise_cause: assert property ($rose(dta_n) |-> $past(cs_n || ds_n))
      else $error("ack rose under strobe");
   a_read_drive: assert property (!dta_n && !cs_n && rw |-> rdata_oe)
      else $error("read data not driven");
   a_bus_fight: assert property (!(rdata_oe && wdata_oe)) else $error("bus fight");
   a_strobe_hold: assert property (s_req |=>
      !cs_n && !ds_n && $stable(addr) && $stable(rw))
      else $error("request moved");
   a_write_drive: assert property (!ds_n && !rw |-> wdata_oe)
      else $error("write data not driven");
   c_read: cover property (!cs_n && !ds_n && dta_n && rw);
   c_write: cover property (!cs_n && !ds_n && dta_n && !rw);
   c_mem: cover property (!cs_n && !ds_n && dta_n && addr[14]);
endmodule : tcm_props
`default_nettype wire

// >>> verif/tdm_connection_memory_block_prog_test.sv
// Purpose: Self-checking bench joining host end and device end.
// Assumes: DEPTH 64 and FILL_LIMIT 100 keep a fill short.
// Notes: Memory models live here; a fill rewrites them whole.
`timescale 1ns/1ps
`default_nettype none
module tdm_connection_memory_block_prog_test;
   import tcm_pkg::*;
   localparam int DEP = 64;
   localparam logic [14:0] CR = {1'b0, REG_CTRL};
   localparam logic [14:0] FR = {1'b0, REG_FILL};
   logic sys_clk, resetn, cmd_req, cmd_write, cmd_ready, rsp_valid, slot_req, slot_valid;
   logic fill_busy, b;
   logic [14:0] cmd_addr;
   logic [15:0] cmd_wdata, rsp_rdata, w;
   logic [1:0] strap, rate_32, src_is_local, msg_mode, drive_en, force_high;
   logic [13:0] slot_addr;
   logic [1:0][4:0] src_stream;
   logic [1:0][8:0] src_chan;
   logic [1:0][7:0] msg_byte;
   logic [5:0] f;
   logic [15:0] lc [DEP];
   logic [15:0] bk [DEP];
   int n_errors = 0;
   int checks = 0;
   int n;
   tcm_bus_if bus ();
   tcm_device_end #(.DEPTH(DEP), .FILL_LIMIT(100)) tcm_device_end_i (.sys_clk(sys_clk),
      .resetn(resetn), .bus(bus), .local_reset_output_state(strap[0]),
      .backplane_reset_output_state(strap[1]), .rate_32(rate_32), .slot_req(slot_req),
      .slot_addr(slot_addr), .slot_valid(slot_valid), .src_is_local(src_is_local),
      .src_stream(src_stream), .src_chan(src_chan), .msg_mode(msg_mode), .msg_byte(msg_byte),
      .drive_en(drive_en), .force_high(force_high), .fill_busy(fill_busy));
   tcm_host_end tcm_host_end_i (.sys_clk(sys_clk), .resetn(resetn), .bus(bus),
      .cmd_req(cmd_req), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
   tcm_props tcm_props_i (.sys_clk(sys_clk), .resetn(resetn), .cs_n(bus.cs_n),
      .ds_n(bus.ds_n), .rw(bus.rw), .addr(bus.addr), .wdata(bus.wdata),
      .wdata_oe(bus.wdata_oe), .rdata(bus.rdata), .rdata_oe(bus.rdata_oe), .dta_n(bus.dta_n));
   task automatic stop_test();
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bound(input int k, input int lim);
      if (k >= lim) begin
         chk(16'h0000, 16'h0001);
         stop_test();
      end
   endtask : bound
   function automatic logic [15:0] exp_src(input logic [15:0] x, input logic r);
      if (x[14]) return {8'h00, x[7:0]};
      return r ? {3'h0, x[12:0]} : {2'h0, x[12:8], 1'b0, x[7:0]};
   endfunction : exp_src
   task automatic acc(input logic wr, input logic [14:0] a, input logic [15:0] d);
      int k;
      @(posedge sys_clk);
      cmd_req <= 1'b1;
      cmd_write <= wr;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge sys_clk);
      cmd_req <= 1'b0;
      for (k = 0; k < 40 && rsp_valid !== 1'b1; k++) @(negedge sys_clk);
      bound(k, 40);
      chk(16'(cmd_ready), 16'h0001);
   endtask : acc
   task automatic mem(input logic ms, input int i, input logic wr, input logic [15:0] d);
      acc(1'b1, CR, {13'h0000, ms ? MS_BACKPLANE : MS_LOCAL});
      acc(wr, {1'b1, 14'(i)}, d);
   endtask : mem
   task automatic look(input int i);
      logic [15:0] x;
      logic [15:0] y;
      @(posedge sys_clk);
      slot_req <= 1'b1;
      slot_addr <= 14'(i);
      rate_32 <= 2'($urandom);
      @(posedge sys_clk);
      slot_req <= 1'b0;
      @(negedge sys_clk);
      chk(16'(slot_valid), 16'h0001);
      chk(16'(force_high), 16'h0000);
      for (int p = 0; p < 2; p++) begin
         x = p ? bk[i] : lc[i];
         chk(16'(src_is_local[p]), 16'(x[15] ^ p[0]));
         chk(16'({msg_mode[p], drive_en[p]}), 16'(x[14:13]));
         y = x[14] ? 16'(msg_byte[p]) : 16'({src_stream[p], src_chan[p]});
         chk(y, exp_src(x, rate_32[p]));
      end
   endtask : look
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      void'($urandom(32'h1c34_05fc));
      {resetn, cmd_req, cmd_write, slot_req, rate_32} = '0;
      {cmd_addr, cmd_wdata, slot_addr} = '0;
      strap = 2'($urandom);
      repeat (15) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(16'({force_high, drive_en}), 16'({~strap, ~strap}));
      @(posedge sys_clk);
      resetn <= 1'b1;
      acc(1'b0, FR, 16'h0000);
      chk(rsp_rdata, FILL_RESET);
      acc(1'b0, 15'h0005, 16'h0000);
      chk(rsp_rdata, 16'h0000);
      // Enable while the mode bit has not risen since reset must be ignored.
      acc(1'b1, FR, 16'h0001);
      chk(16'(fill_busy), 16'h0000);
      f = 6'($urandom);
      acc(1'b1, CR, 16'h0008);
      acc(1'b1, FR, {9'h000, f, 1'b1});
      for (n = 0; n < 110 && fill_busy !== 1'b0; n++) @(negedge sys_clk);
      bound(n, 110);
      acc(1'b0, FR, 16'h0000);
      chk(rsp_rdata, {9'h000, f, 1'b0});
      for (int m = 0; m < DEP; m++) begin
         lc[m] = {f[2:0], 13'h0000};
         bk[m] = {f[5:3], 13'h0000};
         mem(1'b0, m, 1'b0, 16'h0000);
         chk(rsp_rdata, lc[m]);
         mem(1'b1, m, 1'b0, 16'h0000);
         chk(rsp_rdata, bk[m]);
      end
      for (int t = 0; t < 40; t++) begin
         n = t ? $urandom_range(DEP - 1) : DEP - 1;
         w = 16'($urandom);
         b = 1'($urandom);
         if (b) bk[n] = w;
         else lc[n] = w;
         mem(b, n, 1'b1, w);
         mem(b, n, 1'b0, 16'h0000);
         chk(rsp_rdata, w);
         look(n);
      end
      acc(1'b1, CR, 16'h0002);
      acc(1'b0, CR, 16'h0000);
      chk(rsp_rdata, 16'h0002);
      acc(1'b1, 15'h4000, 16'hffff);
      acc(1'b0, 15'h4000, 16'h0000);
      chk(rsp_rdata, 16'h0000);
      mem(1'b0, 0, 1'b0, 16'h0000);
      chk(rsp_rdata, lc[0]);
      for (int k = 0; k < 2; k++) begin
         acc(1'b1, CR, 16'h0000);
         acc(1'b1, CR, 16'h0008);
         acc(1'b1, FR, 16'h0001);
         chk(16'(fill_busy), 16'h0001);
         acc(1'b1, k ? CR : FR, 16'h0000);
         chk(16'(fill_busy), 16'h0000);
      end
      // A second reset with the straps flipped covers the other strap levels.
      acc(1'b1, FR, 16'h0076);
      @(posedge sys_clk);
      resetn <= 1'b0;
      strap <= ~strap;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(16'({force_high, drive_en}), 16'({~strap, ~strap}));
      @(posedge sys_clk);
      resetn <= 1'b1;
      acc(1'b0, FR, 16'h0000);
      chk(rsp_rdata, FILL_RESET);
      stop_test();
   end
endmodule : tdm_connection_memory_block_prog_test
`default_nettype wire
